// >>> hw/casr_bank.sv
// serial write port and register bank of one front-end channel
// assumes serial clock, strobe, data and sync pins are asynchronous to clk
`timescale 1ns/100ps
`default_nettype none

module casr_bank (
    input  wire logic                                       clk,
    input  wire logic                                       rst,
    input  wire logic                                       clk_en,
    input  wire logic                                       serial_clock_in,
    input  wire logic                                       serial_load_strobe,
    input  wire logic                                       serial_line_in,
    input  wire logic                                       vertical_sync_in,
    input  wire logic                                       horizontal_sync_in,
    output var  logic [casr_pkg::CASR_NREG-1:0][23:0]       active_regs,
    output var  casr_pkg::casr_status_s                     status
);
    import casr_pkg::*;

    function automatic casr_lookup_s find_reg(input logic [7:0] a);
        casr_lookup_s r;
        r = '0;
        for (int k = 0; k < CASR_NREG; k++) begin
            if (CASR_ADDR[k] == a) begin
                r.hit = 1'b1;
                r.idx = CASR_IDX_W'(k);
            end
        end
        return r;
    endfunction

    // two-flop synchronisers plus one history stage for edges
    logic [2:0] sck_q, sl_q, sd_q, vd_q, hd_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            sck_q <= '0;
            sl_q  <= 3'b111;
            sd_q  <= '0;
            // idle sync level is high, so no false edge follows reset
            vd_q  <= 3'b111;
            hd_q  <= 3'b111;
        end else if (clk_en) begin
            sck_q <= {sck_q[1:0], serial_clock_in};
            sl_q  <= {sl_q[1:0], serial_load_strobe};
            sd_q  <= {sd_q[1:0], serial_line_in};
            vd_q  <= {vd_q[1:0], vertical_sync_in};
            hd_q  <= {hd_q[1:0], horizontal_sync_in};
        end
    end

    logic [23:0] shadow [CASR_NREG];
    logic [CASR_NREG-1:0] pend;

    logic edge_rising;
    logic bit_take, sl_rise, vd_evt, hd_evt;
    assign edge_rising = active_regs[CASR_IDX_EDGE_SEL][0];
    // data line delayed like the clock, so the sampled bit matches the edge
    assign bit_take = clk_en && !sl_q[1] && sck_q[1] && !sck_q[2];
    assign sl_rise  = clk_en && sl_q[1] && !sl_q[2];
    assign vd_evt   = clk_en && (edge_rising ? (vd_q[1] && !vd_q[2])
                                             : (!vd_q[1] && vd_q[2]));
    assign hd_evt   = clk_en && (edge_rising ? (hd_q[1] && !hd_q[2])
                                             : (!hd_q[1] && hd_q[2]));

    // serial engine
    logic [23:0] shreg;
    logic [4:0]  bit_cnt;
    logic        addr_phase;
    logic [7:0]  wr_addr;
    logic [23:0] next_word;
    logic        word_done, addr_done;

    assign next_word = {sd_q[1], shreg[23:1]};
    assign addr_done = bit_take && addr_phase && bit_cnt == CASR_ADDR_LAST;
    assign word_done = bit_take && !addr_phase && bit_cnt == CASR_DATA_LAST;

    always_ff @(posedge clk) begin
        if (rst) begin
            shreg      <= '0;
            bit_cnt    <= '0;
            addr_phase <= 1'b1;
            wr_addr    <= '0;
        end else if (clk_en) begin
            if (sl_q[1]) begin
                // partial word is dropped when the strobe ends the frame
                bit_cnt    <= '0;
                addr_phase <= 1'b1;
            end else if (bit_take) begin
                shreg <= next_word;
                if (addr_done) begin
                    wr_addr    <= next_word[23:16];
                    addr_phase <= 1'b0;
                    bit_cnt    <= '0;
                end else if (word_done) begin
                    wr_addr <= wr_addr + 8'h01;
                    bit_cnt <= '0;
                end else begin
                    bit_cnt <= bit_cnt + 5'd1;
                end
            end
        end
    end

    casr_lookup_s wr_look;
    logic         wr_hit;
    assign wr_look = find_reg(wr_addr);
    // unmapped addresses still advance the burst address but store nothing
    assign wr_hit  = word_done && wr_look.hit;

    logic soft_go;
    assign soft_go = sl_rise && shadow[CASR_IDX_SOFT_RESET][0];

    // sync boundary tracking
    logic [CASR_LINE_W-1:0] line_cnt;
    logic                   armed;
    logic                   apply_now;

    assign apply_now = hd_evt && armed
                    && line_cnt == active_regs[CASR_IDX_APPLY_LINE][CASR_LINE_W-1:0]
                    && !active_regs[CASR_IDX_INHIBIT][0];

    always_ff @(posedge clk) begin
        if (rst || soft_go) begin
            line_cnt <= '0;
            armed    <= 1'b0;
        end else if (clk_en) begin
            if (vd_evt) begin
                line_cnt <= '0;
            end else if (hd_evt) begin
                line_cnt <= line_cnt + CASR_LINE_W'(1);
            end
            // arming at the vsync edge means updates wait for the next field
            if (vd_evt && |pend) begin
                armed <= 1'b1;
            end else if (apply_now) begin
                armed <= 1'b0;
            end
        end
    end

    for (genvar i = 0; i < CASR_NREG; i++) begin : g_reg
        logic wr_this;
        assign wr_this = wr_hit && wr_look.idx == CASR_IDX_W'(i);

        always_ff @(posedge clk) begin
            if (rst || soft_go) begin
                shadow[i] <= CASR_RESET[i];
            end else if (wr_this) begin
                shadow[i] <= next_word & casr_mask(CASR_WIDTH[i]);
            end
        end

        if (CASR_ON_STROBE[i]) begin : g_strobe
            always_ff @(posedge clk) begin
                if (rst || soft_go) begin
                    active_regs[i] <= CASR_RESET[i];
                end else if (sl_rise) begin
                    active_regs[i] <= shadow[i];
                end
            end
            assign pend[i] = 1'b0;
        end else begin : g_sync
            logic pend_q;
            always_ff @(posedge clk) begin
                if (rst || soft_go) begin
                    active_regs[i] <= CASR_RESET[i];
                    pend_q         <= 1'b0;
                end else if (clk_en) begin
                    if (apply_now && pend_q) begin
                        active_regs[i] <= shadow[i];
                    end
                    // a write landing on the apply cycle stays pending
                    if (wr_this) begin
                        pend_q <= 1'b1;
                    end else if (apply_now) begin
                        pend_q <= 1'b0;
                    end
                end
            end
            assign pend[i] = pend_q;
        end
    end

    // field force is a one-shot request taken at the next vsync
    logic field_touch;
    logic force_req;

    always_ff @(posedge clk) begin
        if (rst || soft_go) begin
            field_touch <= 1'b0;
            force_req   <= 1'b0;
        end else if (clk_en) begin
            if (wr_hit && wr_look.idx == CASR_IDX_W'(CASR_IDX_FIELD)) begin
                field_touch <= 1'b1;
            end else if (sl_rise) begin
                field_touch <= 1'b0;
            end
            if (sl_rise && field_touch) begin
                force_req <= 1'b1;
            end else if (vd_evt) begin
                force_req <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst || soft_go) begin
            status <= '0;
        end else if (clk_en) begin
            if (vd_evt) begin
                if (force_req) begin
                    status.field_number <= (active_regs[CASR_IDX_FIELD][1:0] >= CASR_FIELD_LAST)
                                         ? CASR_FIELD_LAST
                                         : active_regs[CASR_IDX_FIELD][1:0];
                end else if (status.field_number >= CASR_FIELD_LAST) begin
                    status.field_number <= 2'h0;
                end else begin
                    status.field_number <= status.field_number + 2'h1;
                end
            end
            status.line_count          <= line_cnt;
            status.outputs_active      <= active_regs[CASR_IDX_OUT_ENABLE][0];
            status.timing_core_reset_n <= active_regs[CASR_IDX_CORE_RUN][0];
            status.blanking_realign    <= active_regs[CASR_IDX_REALIGN][0];
            status.update_armed        <= armed;
        end
    end

endmodule // casr_bank

`default_nettype wire

// >>> shared/casr_pkg.sv
// register map, field layout and carrier types of the serial register bank
// assumes one channel; the other channel is a second instance
// How it works
// - each write is address byte, data word
// - address and data shift LSB first
// - short data word leaves register untouched
// - further words go to next address
// - bursts start anywhere, cover whole space
// - listed registers apply at strobe rise
// - others apply at line after vsync
// - line select register picks apply line
// - inhibit bit holds back sync updates
// - soft reset restores defaults, self clears
// - output enable low forces outputs inactive
// - core run bit low holds core reset
// - edge select picks falling or rising syncs
// - blanking realign bit aligns blanking to H1
// - everything runs on master clock, sync aligned
package casr_pkg;

    localparam int CASR_NREG   = 23;
    localparam int CASR_DATA_W = 24;
    localparam int CASR_ADDR_W = 8;
    localparam int CASR_IDX_W  = 5;
    localparam int CASR_LINE_W = 12;
    localparam logic [4:0] CASR_ADDR_LAST = 5'd7;
    localparam logic [4:0] CASR_DATA_LAST = 5'd23;

    // storage order of the implemented registers
    localparam logic [7:0] CASR_ADDR [CASR_NREG] = '{
        8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15,
        8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'he8, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64};
    localparam int CASR_WIDTH [CASR_NREG] = '{
        12, 10, 8, 12, 18, 18, 1, 1, 1, 12, 1, 1, 2, 1, 2, 1, 1, 12, 13, 13, 15, 12, 8};
    localparam logic [23:0] CASR_RESET [CASR_NREG] = '{
        24'h000004, 24'h000000, 24'h000080, 24'h000004, 24'h000000, 24'h000000,
        24'h000000, 24'h000000, 24'h000000, 24'h000000, 24'h000000, 24'h000000,
        24'h000000, 24'h000000, 24'h000000, 24'h000000, 24'h000000, 24'h000000,
        24'h001001, 24'h000801, 24'h000000, 24'h000024, 24'h000000};
    // 1 = applied at strobe rise, 0 = applied on the sync boundary
    localparam logic [CASR_NREG-1:0] CASR_ON_STROBE = 23'b111_1100_0011_1101_0100_1001;

    localparam int CASR_IDX_SOFT_RESET = 6;
    localparam int CASR_IDX_OUT_ENABLE = 7;
    localparam int CASR_IDX_CORE_RUN   = 8;
    localparam int CASR_IDX_APPLY_LINE = 9;
    localparam int CASR_IDX_INHIBIT    = 10;
    localparam int CASR_IDX_EDGE_SEL   = 11;
    localparam int CASR_IDX_FIELD      = 12;
    localparam int CASR_IDX_REALIGN    = 13;

    localparam logic [1:0] CASR_FIELD_LAST = 2'd2;

    typedef struct packed {
        logic                    hit;
        logic [CASR_IDX_W-1:0]   idx;
    } casr_lookup_s;

    typedef struct packed {
        logic [1:0]              field_number;
        logic [CASR_LINE_W-1:0]  line_count;
        logic                    outputs_active;
        logic                    timing_core_reset_n;
        logic                    blanking_realign;
        logic                    update_armed;
    } casr_status_s;

    function automatic logic [23:0] casr_mask(input int w);
        return 24'((25'd1 << w) - 25'd1);
    endfunction

endpackage

// >>> tb/casr_bank_monitor.sv
// port assertions of the serial register bank
// assumes binding onto casr_bank, one clock domain
`timescale 1ns/100ps
`default_nettype none
module casr_bank_monitor (
    input wire logic                                 clk,
    input wire logic                                 rst,
    input wire logic                                 clk_en,
    input wire logic                                 serial_load_strobe,
    input wire logic                                 horizontal_sync_in,
    input wire logic [casr_pkg::CASR_NREG-1:0][23:0] active_regs,
    input wire casr_pkg::casr_status_s               status
);
    import casr_pkg::*;
    logic [CASR_NREG-1:0][23:0] dflt;
    logic [CASR_NREG-1:0][23:0] wmask;
    logic [CASR_NREG-1:0][23:0] smask;
    always_comb begin
        for (int i = 0; i < CASR_NREG; i++) begin
            dflt[i] = CASR_RESET[i];
            wmask[i] = 24'hffffff >> (24 - CASR_WIDTH[i]);
            smask[i] = {24{CASR_ON_STROBE[i]}};
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_reset_value: assert property ($fell(rst) |-> active_regs == dflt && status == '0)
        else $error("registers not at defaults after reset");
    chk_width_mask: assert property ((active_regs & ~wmask) == '0)
        else $error("bits above register width set");
    chk_strobe_hold: assert property (!serial_load_strobe [*6] |-> $stable(active_regs & smask))
        else $error("strobe register changed inside a frame");
    chk_sync_hold: assert property (($stable(horizontal_sync_in) && $stable(serial_load_strobe)) [*8]
        |-> $stable(active_regs & ~smask))
        else $error("sync register changed off a line boundary");
    chk_out_status: assert property ($rose(active_regs[CASR_IDX_OUT_ENABLE][0]) |=> status.outputs_active)
        else $error("outputs stayed inactive");
    chk_core_status: assert property (status.timing_core_reset_n |-> $past(active_regs[CASR_IDX_CORE_RUN][0]))
        else $error("core released without run bit");
    chk_realign_flag: assert property ($rose(active_regs[CASR_IDX_REALIGN][0]) |=> status.blanking_realign)
        else $error("realign flag not following register");
    chk_soft_clear: assert property (active_regs[CASR_IDX_SOFT_RESET] == '0)
        else $error("soft reset bit not cleared");
    chk_field_range: assert property (status.field_number <= CASR_FIELD_LAST)
        else $error("field number out of range");
    chk_frozen_hold: assert property (!clk_en |=> $stable(active_regs) && $stable(status))
        else $error("state moved with clock enable low");
endmodule // casr_bank_monitor
`default_nettype wire

// >>> tb/casr_host.sv
// image processor model: serial frames and sync pulses
// assumes a free 125 ns serial bit time, unrelated to clk
`timescale 1ns/100ps
`default_nettype none
module casr_host (
    output var logic serial_clock_in,
    output var logic serial_load_strobe,
    output var logic serial_line_in,
    output var logic vertical_sync_in,
    output var logic horizontal_sync_in
);
    initial begin
        {serial_clock_in, serial_line_in} = 2'b00;
        {serial_load_strobe, vertical_sync_in, horizontal_sync_in} = 3'b111;
    end
    // n data bits after the address; n below 24 makes a short word
    task automatic frame(input logic [7:0] a, input logic [47:0] d, input int n);
        logic [55:0] bits;
        bits = {d, a};
        serial_load_strobe = 1'b0;
        #50;
        for (int i = 0; i < n + 8; i++) begin
            serial_line_in = bits[i];
            #62.5 serial_clock_in = 1'b1;
            #62.5 serial_clock_in = 1'b0;
        end
        #50 serial_load_strobe = 1'b1;
        // released line must not look like held data
        serial_line_in = ~serial_line_in;
        #100;
    endtask
    task automatic pulse(input bit v);
        if (v) vertical_sync_in = 1'b0;
        else horizontal_sync_in = 1'b0;
        #100 {vertical_sync_in, horizontal_sync_in} = 2'b11;
        #100;
    endtask
    // single level step on the line sync, to tell the two edges apart
    task automatic hsync_level(input logic lv);
        horizontal_sync_in = lv;
        #100;
    endtask
endmodule // casr_host
`default_nettype wire

// >>> tb/tb_top.sv
// register bank testbench: serial writes, sync boundaries, reset paths
// assumes casr_bank and casr_host, checker bound below
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import casr_pkg::*;
    logic clk, rst, clk_en;
    wire logic sck, sl, sd, vs, hs;
    logic [CASR_NREG-1:0][23:0] regs;
    logic [CASR_NREG-1:0][23:0] regs_b;
    casr_status_s st;
    int n_errors = 0;
    int n_tests = 0;
    casr_host host (.serial_clock_in(sck), .serial_load_strobe(sl), .serial_line_in(sd),
        .vertical_sync_in(vs), .horizontal_sync_in(hs));
    casr_bank dut (.clk(clk), .rst(rst), .clk_en(clk_en), .serial_clock_in(sck),
        .serial_load_strobe(sl), .serial_line_in(sd), .vertical_sync_in(vs),
        .horizontal_sync_in(hs), .active_regs(regs), .status(st));
    // second channel on the same strobe and data lines
    casr_bank dut_b (.clk(clk), .rst(rst), .clk_en(clk_en), .serial_clock_in(sck),
        .serial_load_strobe(sl), .serial_line_in(sd), .vertical_sync_in(vs),
        .horizontal_sync_in(hs), .active_regs(regs_b), .status());
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic complete_run();
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        host.frame(a, {24'h0, d}, 24);
        ticks(8);
    endtask
    task automatic sync(input int nh);
        host.pulse(1'b1);
        repeat (nh) host.pulse(1'b0);
        ticks(8);
    endtask
    task automatic defaults();
        for (int i = 0; i < CASR_NREG; i++) check(regs[i], CASR_RESET[i]);
    endtask
    initial begin
        #500us n_errors++;
        complete_run();
    end
    initial begin
        rst = 1'b1;
        clk_en = 1'b1;
        ticks(20);
        rst = 1'b0;
        ticks(5);
        defaults();
        wr(8'h12, 24'h1);
        check(regs[CASR_IDX_CORE_RUN], 24'h1);
        check(24'(st.timing_core_reset_n), 24'h1);
        wr(8'h11, 24'h1);
        check(regs[CASR_IDX_OUT_ENABLE], 24'h0);
        wr(8'h01, 24'h0);
        host.frame(8'h02, 48'h000123_ffff55, 48);
        ticks(8);
        check(regs[3], 24'h123);
        check(regs[2], 24'h80);
        sync(1);
        check(24'(st.outputs_active), 24'h1);
        check(regs[2], 24'h55);
        check(regs_b[2], 24'h55);
        host.frame(8'h17, 48'hfffff, 20);
        ticks(8);
        check(regs[CASR_IDX_REALIGN], 24'h0);
        wr(8'h17, 24'h1);
        check(24'(st.blanking_realign), 24'h1);
        wr(8'h14, 24'h1);
        wr(8'h02, 24'h11);
        sync(1);
        check(regs[2], 24'h55);
        wr(8'h14, 24'h0);
        sync(1);
        check(regs[2], 24'h11);
        wr(8'h13, 24'h2);
        sync(1);
        wr(8'h02, 24'h22);
        sync(2);
        check(regs[2], 24'h11);
        check(24'(st.line_count), 24'h2);
        check(24'(st.update_armed), 24'h1);
        host.pulse(1'b0);
        ticks(8);
        check(regs[2], 24'h22);
        wr(8'h16, 24'h3);
        sync(0);
        check(24'(st.field_number), 24'h2);
        wr(8'h15, 24'h1);
        wr(8'h02, 24'h33);
        sync(2);
        check(24'(st.field_number), 24'h0);
        host.hsync_level(1'b0);
        ticks(8);
        check(regs[2], 24'h22);
        host.hsync_level(1'b1);
        ticks(8);
        check(regs[2], 24'h33);
        check(24'(st.update_armed), 24'h0);
        clk_en = 1'b0;
        wr(8'h12, 24'h0);
        clk_en = 1'b1;
        ticks(5);
        check(regs[CASR_IDX_CORE_RUN], 24'h1);
        wr(8'h10, 24'h1);
        defaults();
        complete_run();
    end
endmodule // tb_top
bind casr_bank casr_bank_monitor chk (.clk(clk), .rst(rst), .clk_en(clk_en),
    .serial_load_strobe(serial_load_strobe), .horizontal_sync_in(horizontal_sync_in),
    .active_regs(active_regs), .status(status));
`default_nettype wire
